// >>> src/trailer_cmd_rx.sv
// Trailer light module command receiver with APB configuration
// Notes on behaviour
// - Decode slow or fast IR protocol
// - Link lost 2 s: lights off, motor stopped unless manual switch closed
// - On link loss servos go neutral or hold
// - Setting picks neutral or hold for servos
// - Blink status LED while link is good
// - Repeat received IR stream to next trailer
// - Light commands obeyed regardless of train ID
// - Active ID limits servo/motor to matching module
// - Non-matching module holds servo and motor
// - No active ID: obey all servo/motor commands
// - Power-on starts with no active ID
// - Own train ID is a writable setting
// - Manual switch drives motor without remote
// - Manual motor speed from stored setting
`timescale 1ns/10ps
`default_nettype none
module trailer_cmd_rx #(
  parameter int unsigned LINK_TIMEOUT_CYC = trailer_pkg::LINK_TIMEOUT_CYC,
  parameter int unsigned BLINK_HALF_CYC = trailer_pkg::BLINK_HALF_CYC,
  parameter int unsigned SLOW_UNIT_CYC = trailer_pkg::SLOW_UNIT_CYC,
  parameter int unsigned FAST_UNIT_CYC = trailer_pkg::FAST_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // IR link
  input wire logic ir_rx_n_i,
  output logic ir_tx_o,
  // Manual motor switch, low when closed
  input wire logic manual_sw_n_i,
  // Loads and indicator
  output logic [15:0] light_o,
  output logic [31:0] servo_pos_o,
  output logic [7:0] motor_speed_o,
  output logic motor_dir_o,
  output logic status_led_o
);
  frame_if fif ();

  logic [15:0] ctrl_r, ctrl_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic hit_r, hit_nxt;
  logic [2:0] msync_r;
  logic manual_r, manual_nxt;
  logic [31:0] tmo_r, tmo_nxt;
  logic link_ok;
  logic [15:0] light_r, light_nxt;
  logic [7:0] servo_r [4];
  logic [7:0] servo_nxt [4];
  logic [7:0] rspd_r, rspd_nxt;
  logic rdir_r, rdir_nxt;
  logic [2:0] train_r, train_nxt;
  logic [7:0] mspd_r, mspd_nxt;
  logic mdir_r, mdir_nxt;
  logic [31:0] blink_r, blink_nxt;
  logic led_r, led_nxt;
  logic tx_r, tx_nxt;
  logic [3:0] kind;
  logic for_me;
  logic setup_ph, wr_acc;
  logic [31:0] status_w, servo_w;

  // Map hit check, used for the error answer and write enable; the read mux decodes the address itself
  function automatic logic addr_known(input logic [11:0] a);
    if (a == trailer_pkg::ADDR_CTRL)
      return 1'b1;
    else if (a == trailer_pkg::ADDR_STATUS)
      return 1'b1;
    else if (a == trailer_pkg::ADDR_LIGHTS)
      return 1'b1;
    else if (a == trailer_pkg::ADDR_SERVO)
      return 1'b1;
    else
      return 1'b0;
  endfunction

  // Frame decoder; protocol speed comes from the control register
  ir_frame_rx #(
    .SLOW_UNIT_CYC(SLOW_UNIT_CYC),
    .FAST_UNIT_CYC(FAST_UNIT_CYC)
  ) u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ir_rx_n_i(ir_rx_n_i),
    .fif(fif.rx)
  );
  assign fif.fast_sel = ctrl_r[trailer_pkg::CTRL_FAST_BIT];

  // Frame fields and train filter
  assign kind = fif.frame_data[trailer_pkg::KIND_LSB +: 4];
  assign for_me = (train_r == 3'h0)
    || (train_r == ctrl_r[trailer_pkg::CTRL_ID_LSB +: 3]);

  // Zero-wait APB; read data captured in the setup cycle
  assign setup_ph = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pwrite_i && hit_r;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit_r;

  // Status and servo words seen by software
  always_comb
  begin
    status_w = 32'h0;
    status_w[trailer_pkg::STAT_LINK_BIT] = link_ok;
    status_w[trailer_pkg::STAT_MANUAL_BIT] = manual_r;
    status_w[trailer_pkg::STAT_MOTOR_BIT] = (mspd_r != 8'h0);
    status_w[trailer_pkg::STAT_ID_LSB +: 3] = train_r;
    servo_w = {servo_r[3], servo_r[2], servo_r[1], servo_r[0]};
  end

  // Register file next state
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    hit_nxt = hit_r;
    rd_nxt = rd_r;
    if (setup_ph)
    begin
      hit_nxt = addr_known(paddr_i);
      if (paddr_i == trailer_pkg::ADDR_CTRL)
        rd_nxt = {16'h0, ctrl_r};
      else if (paddr_i == trailer_pkg::ADDR_STATUS)
        rd_nxt = status_w;
      else if (paddr_i == trailer_pkg::ADDR_LIGHTS)
        rd_nxt = {16'h0, light_r};
      else if (paddr_i == trailer_pkg::ADDR_SERVO)
        rd_nxt = servo_w;
      else
        rd_nxt = 32'h0;
    end
    // Own ID, fail-safe choice and manual speed live here
    if (wr_acc && paddr_i == trailer_pkg::ADDR_CTRL)
      ctrl_nxt = pwdata_i[15:0] & trailer_pkg::CTRL_MASK;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= trailer_pkg::CTRL_RST;
      hit_r <= 1'b0;
      rd_r <= 32'h0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      hit_r <= hit_nxt;
      rd_r <= rd_nxt;
    end
  end
  assign prdata_o = rd_r;

  // Manual switch: three flops, change taken when the last two agree
  always_comb
  begin
    manual_nxt = (msync_r[1] == msync_r[2]) ? msync_r[2] : manual_r;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      msync_r <= 3'h0;
      manual_r <= 1'b0;
    end
    else
    begin
      msync_r <= {msync_r[1:0], ~manual_sw_n_i};
      manual_r <= manual_nxt;
    end
  end

  // Link watchdog; starts expired so only the manual switch drives a load before a frame
  always_comb
  begin
    if (fif.frame_vld)
      tmo_nxt = 32'h0;
    else if (tmo_r < 32'(LINK_TIMEOUT_CYC))
      tmo_nxt = tmo_r + 32'h1;
    else
      tmo_nxt = tmo_r;
  end
  assign link_ok = (tmo_r < 32'(LINK_TIMEOUT_CYC));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      tmo_r <= 32'(LINK_TIMEOUT_CYC);
    else
      tmo_r <= tmo_nxt;
  end

  // Command execution and fail-safe
  always_comb
  begin
    light_nxt = light_r;
    rspd_nxt = rspd_r;
    rdir_nxt = rdir_r;
    train_nxt = train_r;
    for (int i = 0; i < 4; i++)
      servo_nxt[i] = servo_r[i];
    if (fif.frame_vld)
    begin
      if (kind == trailer_pkg::KIND_LIGHTS)
        light_nxt = fif.frame_data[15:0];
      else if (kind == trailer_pkg::KIND_SELECT)
        train_nxt = fif.frame_data[2:0];
      else if (kind == trailer_pkg::KIND_SERVO && for_me)
      begin
        // Other modules leave servo untouched
        for (int i = 0; i < 4; i++)
          if (fif.frame_data[trailer_pkg::SERVO_IDX_LSB +: 2] == 2'(i))
            servo_nxt[i] = fif.frame_data[7:0];
      end
      else if (kind == trailer_pkg::KIND_MOTOR && for_me)
      begin
        rspd_nxt = fif.frame_data[7:0];
        rdir_nxt = fif.frame_data[trailer_pkg::MOTOR_DIR_BIT];
      end
    end
    else if (!link_ok)
    begin
      // A frame in the same cycle wins over lost link; a fresh frame lifts it next cycle
      light_nxt = 16'h0;
      rspd_nxt = 8'h0;
      if (!ctrl_r[trailer_pkg::CTRL_HOLD_BIT])
        for (int i = 0; i < 4; i++)
          servo_nxt[i] = trailer_pkg::SERVO_NEUTRAL;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      light_r <= 16'h0;
      rspd_r <= 8'h0;
      rdir_r <= 1'b0;
      train_r <= 3'h0;
      for (int i = 0; i < 4; i++)
        servo_r[i] <= trailer_pkg::SERVO_NEUTRAL;
    end
    else
    begin
      light_r <= light_nxt;
      rspd_r <= rspd_nxt;
      rdir_r <= rdir_nxt;
      train_r <= train_nxt;
      for (int i = 0; i < 4; i++)
        servo_r[i] <= servo_nxt[i];
    end
  end

  // Motor: manual switch overrides remote, even with link lost
  always_comb
  begin
    if (manual_r)
    begin
      mspd_nxt = ctrl_r[trailer_pkg::CTRL_SPEED_LSB +: 8];
      mdir_nxt = ctrl_r[trailer_pkg::CTRL_MDIR_BIT];
    end
    else
    begin
      mspd_nxt = rspd_r;
      mdir_nxt = rdir_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mspd_r <= 8'h0;
      mdir_r <= 1'b0;
    end
    else
    begin
      mspd_r <= mspd_nxt;
      mdir_r <= mdir_nxt;
    end
  end

  // Status LED: steady with no link, regular blink with link
  always_comb
  begin
    blink_nxt = blink_r + 32'h1;
    led_nxt = led_r;
    if (!link_ok)
    begin
      blink_nxt = 32'h0;
      led_nxt = 1'b1;
    end
    else if (blink_r >= 32'(BLINK_HALF_CYC) - 32'h1)
    begin
      blink_nxt = 32'h0;
      led_nxt = !led_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blink_r <= 32'h0;
      led_r <= 1'b1;
    end
    else
    begin
      blink_r <= blink_nxt;
      led_r <= led_nxt;
    end
  end

  // IR repeater; a few cycles of delay only, pulse widths kept
  always_comb
  begin
    tx_nxt = ctrl_r[trailer_pkg::CTRL_REPEAT_BIT] && fif.ir_mark;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      tx_r <= 1'b0;
    else
      tx_r <= tx_nxt;
  end

  // Outputs
  assign ir_tx_o = tx_r;
  assign light_o = light_r;
  assign servo_pos_o = {servo_r[3], servo_r[2], servo_r[1], servo_r[0]};
  assign motor_speed_o = mspd_r;
  assign motor_dir_o = mdir_r;
  assign status_led_o = led_r;
endmodule // trailer_cmd_rx
`default_nettype wire

// >>> src/trailer_pkg.sv
// Constants shared by the trailer command receiver and its IR frame decoder
package trailer_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned LINK_TIMEOUT_MS = 2000;
  localparam int unsigned LINK_TIMEOUT_CYC = LINK_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_HALF_MS = 50;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned SLOW_UNIT_US = 400;
  localparam int unsigned FAST_UNIT_US = 100;
  localparam int unsigned SLOW_UNIT_CYC = SLOW_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FAST_UNIT_CYC = FAST_UNIT_US * (CLK_HZ / 1_000_000);
  // Frame layout
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam int unsigned KIND_LSB = 28;
  localparam logic [3:0] KIND_LIGHTS = 4'h1;
  localparam logic [3:0] KIND_SERVO = 4'h2;
  localparam logic [3:0] KIND_MOTOR = 4'h3;
  localparam logic [3:0] KIND_SELECT = 4'h4;
  localparam int unsigned SERVO_IDX_LSB = 8;
  localparam int unsigned MOTOR_DIR_BIT = 8;
  localparam logic [7:0] SERVO_NEUTRAL = 8'h80;
  // Register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_LIGHTS = 12'h008;
  localparam logic [11:0] ADDR_SERVO = 12'h00C;
  // Control fields
  localparam int unsigned CTRL_FAST_BIT = 0;
  localparam int unsigned CTRL_HOLD_BIT = 1;
  localparam int unsigned CTRL_REPEAT_BIT = 2;
  localparam int unsigned CTRL_MDIR_BIT = 3;
  localparam int unsigned CTRL_ID_LSB = 4;
  localparam int unsigned CTRL_SPEED_LSB = 8;
  localparam logic [15:0] CTRL_MASK = 16'hFF7F;
  localparam logic [15:0] CTRL_RST = 16'h6610;
  // Status fields
  localparam int unsigned STAT_LINK_BIT = 0;
  localparam int unsigned STAT_MANUAL_BIT = 1;
  localparam int unsigned STAT_MOTOR_BIT = 2;
  localparam int unsigned STAT_ID_LSB = 4;
endpackage

// >>> src/frame_if.sv
// Decoded IR frames passed from the decoder to the command logic
`timescale 1ns/10ps
`default_nettype none
interface frame_if;
  logic fast_sel;
  logic frame_vld;
  logic [31:0] frame_data;
  logic ir_mark;
  modport rx (input fast_sel, output frame_vld, output frame_data, output ir_mark);
  modport core (output fast_sel, input frame_vld, input frame_data, input ir_mark);
endinterface
`default_nettype wire

// >>> src/ir_frame_rx.sv
// IR pulse-distance frame decoder with slow and fast timing
`timescale 1ns/10ps
`default_nettype none
module ir_frame_rx #(
  parameter int unsigned SLOW_UNIT_CYC = trailer_pkg::SLOW_UNIT_CYC,
  parameter int unsigned FAST_UNIT_CYC = trailer_pkg::FAST_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Receiver pin, low during a mark
  input wire logic ir_rx_n_i,
  // Frames out
  frame_if.rx fif
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MARK = 3'b010,
    ST_SPACE = 3'b100
  } rx_state_t;
  rx_state_t st_r, st_nxt;
  logic [2:0] sync_r;
  logic mark_r, mark_nxt;
  logic [31:0] len_r, len_nxt;
  logic [5:0] bits_r, bits_nxt;
  logic [31:0] sh_r, sh_nxt;
  logic vld_r, vld_nxt;
  logic [31:0] unit;

  // Bit unit follows the selected protocol speed
  assign unit = fif.fast_sel ? 32'(FAST_UNIT_CYC) : 32'(SLOW_UNIT_CYC);

  // Space length codes the bit; a long space closes the frame
  always_comb
  begin
    mark_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : mark_r;
    st_nxt = st_r;
    len_nxt = len_r + 32'h1;
    bits_nxt = bits_r;
    sh_nxt = sh_r;
    vld_nxt = 1'b0;
    case (st_r)
      ST_IDLE:
      begin
        len_nxt = 32'h0;
        if (mark_r)
        begin
          st_nxt = ST_MARK;
          bits_nxt = 6'h0;
        end
      end
      ST_MARK:
      begin
        if (!mark_r)
        begin
          st_nxt = ST_SPACE;
          len_nxt = 32'h0;
        end
      end
      ST_SPACE:
      begin
        if (mark_r)
        begin
          st_nxt = ST_MARK;
          sh_nxt = {sh_r[30:0], len_r >= (unit << 1)};
          if (bits_r != 6'h3F) // Saturate so long junk never looks valid
            bits_nxt = bits_r + 6'h1;
        end
        else if (len_r >= (unit << 2))
        begin
          st_nxt = ST_IDLE;
          vld_nxt = (bits_r == trailer_pkg::FRAME_BITS);
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Registers; sync_r[0] feeds only sync_r[1]
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_r <= 3'h0;
      mark_r <= 1'b0;
      st_r <= ST_IDLE;
      len_r <= 32'h0;
      bits_r <= 6'h0;
      sh_r <= 32'h0;
      vld_r <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[1:0], ~ir_rx_n_i};
      mark_r <= mark_nxt;
      st_r <= st_nxt;
      len_r <= len_nxt;
      bits_r <= bits_nxt;
      sh_r <= sh_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign fif.frame_vld = vld_r;
  assign fif.frame_data = sh_r;
  assign fif.ir_mark = mark_r;
endmodule // ir_frame_rx
`default_nettype wire

// >>> tb/trailer_cmd_rx_checker.sv
// Port-level assertions for the trailer command receiver
`timescale 1ns/10ps
`default_nettype none
module trailer_cmd_rx_checker #(
  parameter int unsigned LINK_TIMEOUT_CYC = 4000,
  parameter int unsigned SLOW_UNIT_CYC = 40
) (
  // Clock, reset and APB
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pslverr_o,
  // Link, switch and loads
  input wire logic ir_rx_n_i,
  input wire logic ir_tx_o,
  input wire logic manual_sw_n_i,
  input wire logic [15:0] light_o,
  input wire logic [31:0] servo_pos_o,
  input wire logic [7:0] motor_speed_o,
  input wire logic motor_dir_o,
  input wire logic status_led_o
);
  // Idle margin covers the end gap, sync and output stages
  localparam int LIM = LINK_TIMEOUT_CYC + 4 * SLOW_UNIT_CYC + 16;
  logic [15:0] ctrl_r;
  logic ctrl_wr;
  int idle_cnt;
  int open_cnt;
  int shut_cnt;
  assign ctrl_wr = psel_i && penable_i && pwrite_i && paddr_i == trailer_pkg::ADDR_CTRL;
  // Shadow of CTRL and saturating quiet counters
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= trailer_pkg::CTRL_RST;
      idle_cnt <= 0;
      open_cnt <= 0;
      shut_cnt <= 0;
    end
    else
    begin
      if (ctrl_wr)
        ctrl_r <= pwdata_i[15:0] & trailer_pkg::CTRL_MASK;
      idle_cnt <= !ir_rx_n_i ? 0 : (idle_cnt > LIM ? idle_cnt : idle_cnt + 1);
      open_cnt <= !manual_sw_n_i ? 0 : (open_cnt > 9 ? open_cnt : open_cnt + 1);
      shut_cnt <= (manual_sw_n_i || ctrl_wr) ? 0 : (shut_cnt > 9 ? shut_cnt : shut_cnt + 1);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; $past(rst_i) |-> light_o == 16'h0000 && motor_speed_o == 8'h00
    && servo_pos_o == {4{trailer_pkg::SERVO_NEUTRAL}} && status_led_o; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_loss_light; idle_cnt > LIM |-> light_o == 16'h0000; endproperty
  a_loss_light: assert property (p_loss_light) else $error("lights on, link lost");
  property p_loss_motor; idle_cnt > LIM && open_cnt > 9 |-> motor_speed_o == 8'h00; endproperty
  a_loss_motor: assert property (p_loss_motor) else $error("motor on, link lost");
  property p_loss_servo; idle_cnt > LIM && !ctrl_r[1]
    |-> servo_pos_o == {4{trailer_pkg::SERVO_NEUTRAL}}; endproperty
  a_loss_servo: assert property (p_loss_servo) else $error("servo not neutral");
  property p_led; idle_cnt > LIM |=> $stable(status_led_o); endproperty
  a_led: assert property (p_led) else $error("led blinks, link lost");
  property p_rep_on; (!ir_rx_n_i && ctrl_r[2]) [*8] |-> ir_tx_o; endproperty
  a_rep_on: assert property (p_rep_on) else $error("mark not repeated");
  property p_rep_off; (ir_rx_n_i || !ctrl_r[2]) [*8] |-> !ir_tx_o; endproperty
  a_rep_off: assert property (p_rep_off) else $error("stray repeat mark");
  property p_manual; shut_cnt > 9
    |-> motor_speed_o == ctrl_r[15:8] && motor_dir_o == ctrl_r[3]; endproperty
  a_manual: assert property (p_manual) else $error("manual motor wrong");
  property p_err; pslverr_o == (psel_i && penable_i && paddr_i != trailer_pkg::ADDR_CTRL
    && paddr_i != trailer_pkg::ADDR_STATUS && paddr_i != trailer_pkg::ADDR_LIGHTS
    && paddr_i != trailer_pkg::ADDR_SERVO);
  endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
endmodule // trailer_cmd_rx_checker
bind trailer_cmd_rx trailer_cmd_rx_checker #(.LINK_TIMEOUT_CYC(LINK_TIMEOUT_CYC),
  .SLOW_UNIT_CYC(SLOW_UNIT_CYC)) u_chk (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pslverr_o, .ir_rx_n_i, .ir_tx_o, .manual_sw_n_i, .light_o,
  .servo_pos_o, .motor_speed_o, .motor_dir_o, .status_led_o);
`default_nettype wire

// >>> tb/ir_tx_model.sv
// Behavioural IR transmitter of the towing vehicle
`timescale 1ns/10ps
`default_nettype none
module ir_tx_model #(
  parameter int SLOW_U = 40,
  parameter int FAST_U = 10
) (
  // Clock and receiver pin, high when idle
  input wire logic clk_i,
  output logic ir_n_o
);
  initial ir_n_o = 1'b1;
  // Pulse-distance frame, MSB first; n below 32 makes a short frame
  task automatic send(input logic [31:0] d, input int n, input bit fast);
    int u;
    u = fast ? FAST_U : SLOW_U;
    for (int i = 0; i <= n; i++)
    begin
      ir_n_o <= 1'b0;
      repeat (u) @(posedge clk_i);
      ir_n_o <= 1'b1;
      if (i < n)
        repeat (d[31 - i] ? 3 * u : u) @(posedge clk_i);
    end
    repeat (4 * u + 12) @(posedge clk_i);
  endtask
endmodule // ir_tx_model
`default_nettype wire

// >>> tb/trailer_cmd_rx_tb_top.sv
// Self-checking bench for the trailer command receiver
`timescale 1ns/10ps
`default_nettype none
module trailer_cmd_rx_tb_top;
  localparam int TMO = 4000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic manual_sw_n_i = 1'b1;
  logic ir_rx_n_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic ir_tx_o;
  logic [15:0] light_o;
  logic [31:0] servo_pos_o;
  logic [7:0] motor_speed_o;
  logic motor_dir_o;
  logic status_led_o;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int num_checks = 0;
  int tx_marks = 0;
  int tx_base;
  logic tx_q = 1'b0;

  // Clock at 100 MHz
  always #5 clk_i = ~clk_i;

  // Rising marks on the chain output, so a dead repeater shows up
  always @(posedge clk_i)
  begin
    tx_q <= ir_tx_o;
    if (ir_tx_o && !tx_q)
      tx_marks <= tx_marks + 1;
  end

  // Short counts keep the run brief
  trailer_cmd_rx #(.LINK_TIMEOUT_CYC(TMO), .BLINK_HALF_CYC(50), .SLOW_UNIT_CYC(40),
    .FAST_UNIT_CYC(10)) dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ir_rx_n_i, .ir_tx_o, .manual_sw_n_i,
    .light_o, .servo_pos_o, .motor_speed_o, .motor_dir_o, .status_led_o);
  ir_tx_model #(.SLOW_U(40), .FAST_U(10)) ir (.clk_i(clk_i), .ir_n_o(ir_rx_n_i));

  // Value compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic frame(input logic [31:0] d);
    ir.send(d, 32, 1'b1);
  endtask

  // LED toggles seen over 200 cycles
  task automatic blinks(input int e);
    int n;
    logic p;
    n = 0;
    p = status_led_o;
    repeat (200)
    begin
      @(posedge clk_i);
      if (status_led_o !== p)
        n++;
      p = status_led_o;
    end
    chk("blink", e, n);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog well above the planned sequence
  initial
  begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("ctrl", 12'h000, 32'h00006610);
    rdchk("status", 12'h004, 32'h0);
    apb(12'h010, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    tx_base = tx_marks;
    ir.send(32'h10008001, 32, 1'b0);
    chk("slow light", 32'h8001, {16'h0, light_o});
    chk("no repeat", tx_base, tx_marks);
    apb(12'h000, 1'b1, 32'hFFFF66B5);
    rdchk("ctrl", 12'h000, 32'h00006635);
    frame(32'h40000002);
    tx_base = tx_marks;
    frame(32'h1000A5C3);
    chk("light", 32'hA5C3, {16'h0, light_o});
    chk("repeat", tx_base + 33, tx_marks);
    blinks(4);
    frame(32'h2000013C);
    frame(32'h30000155);
    chk("servo", 32'h80808080, servo_pos_o);
    chk("motor", 32'h0, {24'h0, motor_speed_o});
    rdchk("status", 12'h004, 32'h21);
    frame(32'h40000003);
    frame(32'h2000013C);
    frame(32'h30000155);
    chk("servo", 32'h80803C80, servo_pos_o);
    chk("motor", 32'h155, {23'h0, motor_dir_o, motor_speed_o});
    rdchk("status", 12'h004, 32'h35);
    frame(32'h40000000);
    frame(32'h20000311);
    chk("servo", 32'h11803C80, servo_pos_o);
    // 28 bits would decode as a lights frame if the bit count were not checked
    ir.send(32'h1000FFFF, 28, 1'b1);
    chk("short frame", 32'hA5C3, {16'h0, light_o});
    repeat (TMO + 100) @(posedge clk_i);
    chk("lost light", 32'h0, {16'h0, light_o});
    chk("lost motor", 32'h0, {24'h0, motor_speed_o});
    chk("lost servo", 32'h80808080, servo_pos_o);
    blinks(0);
    rdchk("status", 12'h004, 32'h0);
    apb(12'h000, 1'b1, 32'h0000663F);
    frame(32'h20000022);
    frame(32'h10001234);
    repeat (2500) @(posedge clk_i);
    frame(32'h50000000);
    repeat (2500) @(posedge clk_i);
    chk("refresh", 32'h1234, {16'h0, light_o});
    manual_sw_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("manual", 32'h166, {23'h0, motor_dir_o, motor_speed_o});
    rdchk("status", 12'h004, 32'h7);
    manual_sw_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("manual off", 32'h0, {24'h0, motor_speed_o});
    repeat (TMO + 100) @(posedge clk_i);
    chk("held servo", 32'h80808022, servo_pos_o);
    report_and_stop();
  end
endmodule // trailer_cmd_rx_tb_top
`default_nettype wire
